// file: logic/gpmux_port.sv
// gpmux_port: eight-pin programmable port with modem line mux
//
// What this block does
// - each direction bit makes its pin an input (0) or an output (1).
// - any direction write clears a pending pin-change interrupt.
// - a level read returns each input pin's level (its captured level while latched and pending) and each output's written bit.
// - a level write drives each bit onto its pin when it is an output.
// - an enable bit of one lets a change on its input pin interrupt.
// - in modem mode enable bits 7:4 do nothing; modem irq enable rules.
// - writing control bit 3 resets the device and the bit self-clears.
// - control bit 1 makes pins 7:4 the ring, carrier, ready, set-ready.
// - unlatched: a change interrupts, a read or a return clears it.
// - latched: a change interrupts and captures the new level.
// - latched: a return before the read keeps irq and captured level.
// - in io mode modem inputs do not reach modem status or its irq.
// - in modem mode they do, and modem control bit 0 drives ready.
// - in modem mode bits 7:4 of dir, level and enable do nothing.
`timescale 1ns/10ps
module gpmux_port
   import gpmux_pkg::*;
#(
   parameter int W = gpmux_pkg::GPMUX_W,
   parameter int SRST_CYC = gpmux_pkg::GPMUX_SRST_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [gpmux_pkg::GPMUX_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe,
   input wire logic dtr_level,
   input wire logic modem_irq_en,
   output logic [2:0] modem_status,
   output logic modem_irq,
   output logic pin_irq,
   output logic soft_reset
);
   import gpmux_pkg::*;

   // ----------------------------------------------------------------
   // registers and decode
   // ----------------------------------------------------------------
   logic [W-1:0] dir_q, lvl_q, ien_q, ref_q, cap_q, pend_q;
   logic [W-1:0] pin_s, pin_s_q;
   logic [7:0] ctl_q;
   logic srst_active;
   logic rst_all;
   logic wr_dir, wr_lvl, wr_ien, wr_ctl, rd_lvl;
   logic latch_mode, modem_mode;
   logic [W-1:0] gpio_mask, is_input, chg, eff_en, raw_lvl, rd_view;
   logic [W-1:0] pend_d, ref_d, cap_d, oe_d, out_d;
   logic [W-1:0] rd_clr, set_ev, hold_ref;
   logic [7:0] rdata_d;
   logic [2:0] mst_d;
   logic [2:0] mst_q;
   logic mirq_d;

   assign wr_dir = reg_wr && (reg_addr == GPMUX_IDX_DIR);
   assign wr_lvl = reg_wr && (reg_addr == GPMUX_IDX_LVL);
   assign wr_ien = reg_wr && (reg_addr == GPMUX_IDX_IEN);
   assign wr_ctl = reg_wr && (reg_addr == GPMUX_IDX_CTL);
   assign rd_lvl = reg_rd && (reg_addr == GPMUX_IDX_LVL);
   assign latch_mode = ctl_q[GPMUX_CTL_LATCH];
   assign modem_mode = ctl_q[GPMUX_CTL_MODEM];
   // soft reset also clears this block: it is part of the device
   assign rst_all = srst_active;

   gpmux_sync #(.W(W)) gpmux_sync_inst (
      .clock(clock),
      .reset(reset),
      .async_in(pin_in),
      .sync_out(pin_s)
   );

   gpmux_srst #(.CYC(SRST_CYC)) gpmux_srst_inst (
      .clock(clock),
      .reset(reset),
      .request(wr_ctl && reg_wdata[GPMUX_CTL_SRST]),
      .active(srst_active)
   );

   // ----------------------------------------------------------------
   // change detection
   // ----------------------------------------------------------------
   // upper pins leave gpio control while they serve as modem lines
   assign gpio_mask = modem_mode ? ~W'(GPMUX_UPPER) : {W{1'b1}};
   assign is_input = ~dir_q;
   assign chg = pin_s ^ ref_q;
   assign eff_en = ien_q & is_input & gpio_mask;

   // unlatched: pending follows the difference, so a return clears it
   // latched: pending is sticky; set beats the clearing read
   // a change already pending at the clearing read must not set again
   assign rd_clr = rd_lvl ? pend_q : {W{1'b0}};
   assign set_ev = chg & eff_en & ~rd_clr;
   assign pend_d = wr_dir ? {W{1'b0}} :
      latch_mode ? ((pend_q & ~{W{rd_lvl}}) | set_ev) :
      set_ev;

   // reference moves to the current level at a clearing read or a
   // direction write, so each change is seen once; unwatched pins
   // track the pin, so enabling one later raises nothing stale
   assign hold_ref = pend_q | eff_en;
   assign ref_d = (rd_lvl || wr_dir) ? pin_s :
      ((ref_q & hold_ref) | (pin_s & ~hold_ref));

   // capture the level that caused the interrupt and hold it
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_cap
         assign cap_d[i] = (latch_mode && chg[i] && eff_en[i] &&
            !(pend_q[i] && !rd_lvl)) ? pin_s[i] : cap_q[i];
         assign raw_lvl[i] = (dir_q[i] && gpio_mask[i]) ?
            lvl_q[i] : pin_s[i];
         assign rd_view[i] = (latch_mode && pend_q[i]) ? cap_q[i] : raw_lvl[i];
      end
   endgenerate

   // ----------------------------------------------------------------
   // pin drive and modem lines
   // ----------------------------------------------------------------
   always_comb begin
      oe_d = dir_q & gpio_mask;
      out_d = lvl_q & gpio_mask;
      if (modem_mode) begin
         oe_d[GPMUX_PIN_DTR] = 1'b1;
         out_d[GPMUX_PIN_DTR] = dtr_level;
      end
   end

   // ri, cd, dsr reach modem status only in modem mode
   assign mst_d = modem_mode ? {pin_s[GPMUX_PIN_CD], pin_s[GPMUX_PIN_RI],
      pin_s[GPMUX_PIN_DSR]} : 3'h0;
   assign mirq_d = modem_mode && modem_irq_en &&
      ((pin_s[GPMUX_PIN_CD] ^ pin_s_q[GPMUX_PIN_CD]) |
       (pin_s[GPMUX_PIN_RI] ^ pin_s_q[GPMUX_PIN_RI]) |
       (pin_s[GPMUX_PIN_DSR] ^ pin_s_q[GPMUX_PIN_DSR]));

   always_comb begin
      rdata_d = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            GPMUX_IDX_DIR: rdata_d = dir_q;
            GPMUX_IDX_LVL: rdata_d = rd_view;
            GPMUX_IDX_IEN: rdata_d = ien_q;
            GPMUX_IDX_CTL: rdata_d = ctl_q & GPMUX_CTL_MASK;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dir_q <= W'(GPMUX_RST8);
         lvl_q <= W'(GPMUX_RST8);
         ien_q <= W'(GPMUX_RST8);
         ctl_q <= GPMUX_RST8;
      end else if (rst_all) begin
         dir_q <= W'(GPMUX_RST8);
         lvl_q <= W'(GPMUX_RST8);
         ien_q <= W'(GPMUX_RST8);
         ctl_q <= GPMUX_RST8;
      end else begin
         if (wr_dir) dir_q <= reg_wdata[W-1:0];
         if (wr_lvl) lvl_q <= reg_wdata[W-1:0];
         if (wr_ien) ien_q <= reg_wdata[W-1:0];
         // soft reset bit is never stored, so it always reads zero
         if (wr_ctl) ctl_q <= reg_wdata & GPMUX_CTL_MASK & ~8'h08;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pend_q <= '0;
         ref_q <= '0;
         cap_q <= '0;
         pin_s_q <= '0;
      end else if (rst_all) begin
         pend_q <= '0;
         ref_q <= pin_s;
         cap_q <= '0;
         pin_s_q <= pin_s;
      end else begin
         pend_q <= pend_d;
         ref_q <= ref_d;
         cap_q <= cap_d;
         pin_s_q <= pin_s;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pin_out <= '0;
         pin_oe <= '0;
         reg_rdata <= 8'h00;
         modem_status <= 3'h0;
         modem_irq <= 1'b0;
         pin_irq <= 1'b0;
         soft_reset <= 1'b0;
         mst_q <= 3'h0;
      end else begin
         pin_out <= out_d;
         pin_oe <= rst_all ? '0 : oe_d;
         reg_rdata <= rdata_d;
         mst_q <= mst_d;
         modem_status <= mst_q;
         modem_irq <= mirq_d && !rst_all;
         pin_irq <= |pend_d && !rst_all && !wr_dir;
         soft_reset <= srst_active;
      end
   end
endmodule // gpmux_port

// file: logic/gpmux_pkg.sv
// gpmux_pkg: register indices, field positions and reset values
package gpmux_pkg;
   localparam int GPMUX_W = 8;
   localparam int GPMUX_AW = 2;
   // register indices on the internal register port (our choice)
   localparam logic [1:0] GPMUX_IDX_DIR = 2'h0;
   localparam logic [1:0] GPMUX_IDX_LVL = 2'h1;
   localparam logic [1:0] GPMUX_IDX_IEN = 2'h2;
   localparam logic [1:0] GPMUX_IDX_CTL = 2'h3;
   // control bit positions
   localparam int GPMUX_CTL_LATCH = 0;
   localparam int GPMUX_CTL_MODEM = 1;
   localparam int GPMUX_CTL_SRST = 3;
   localparam logic [7:0] GPMUX_RST8 = 8'h00;
   localparam logic [7:0] GPMUX_CTL_MASK = 8'h0b;
   localparam logic [7:0] GPMUX_UPPER = 8'hf0;
   // modem pin positions, pin 7 down
   localparam int GPMUX_PIN_RI = 7;
   localparam int GPMUX_PIN_CD = 6;
   localparam int GPMUX_PIN_DTR = 5;
   localparam int GPMUX_PIN_DSR = 4;
   localparam int GPMUX_SRST_CYC = 2;
endpackage

// file: logic/gpmux_sync.sv
// gpmux_sync: two-flop synchroniser, one per pin
`timescale 1ns/10ps
module gpmux_sync #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               meta_q[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_q[i] <= async_in[i];
               sync_out[i] <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule // gpmux_sync

// file: logic/gpmux_srst.sv
// gpmux_srst: stretches a soft-reset request into a fixed pulse
`timescale 1ns/10ps
module gpmux_srst #(
   parameter int CYC = 2
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic request,
   output logic active
);
   logic [3:0] cnt_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cnt_q <= 4'h0;
         active <= 1'b0;
      end else if (request) begin
         cnt_q <= 4'(CYC);
         active <= 1'b1;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         active <= (cnt_q != 4'h1);
      end else begin
         active <= 1'b0;
      end
   end
endmodule // gpmux_srst

// file: sim/gpmux_port_checker.sv
// gpmux_port_checker: timing checks on the port block pins
`timescale 1ns/10ps
module gpmux_port_checker
   import gpmux_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [gpmux_pkg::GPMUX_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [W-1:0] pin_in,
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic dtr_level,
   input wire logic modem_irq_en,
   input wire logic [2:0] modem_status,
   input wire logic modem_irq,
   input wire logic pin_irq,
   input wire logic soft_reset
);
   // ---
   // control shadow
   // ---
   logic [1:0] ctl_q;
   wire wr_ok = reg_wr && !soft_reset;
   wire dir_wr = wr_ok && reg_addr == GPMUX_IDX_DIR;
   wire lvl_wr = wr_ok && reg_addr == GPMUX_IDX_LVL;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctl_q <= 2'h0;
      end else if (soft_reset) begin
         ctl_q <= 2'h0;
      end else if (wr_ok && reg_addr == GPMUX_IDX_CTL) begin
         ctl_q <= reg_wdata[1:0];
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // ---
   // assertions
   // ---
   // register written at one edge, pin outputs follow one edge later
   a_dir_sets_oe: assert property (dir_wr |-> ##2
      pin_oe[3:0] == $past(reg_wdata[3:0], 2)) else $error("oe mismatch");
   a_dir_clears_irq: assert property (dir_wr |-> ##1 !pin_irq)
      else $error("irq kept after dir write");
   a_lvl_drives: assert property (lvl_wr |-> ##2
      (pin_out[3:0] & pin_oe[3:0]) ==
      ($past(reg_wdata[3:0], 2) & pin_oe[3:0]))
      else $error("drive mismatch");
   a_rd_outputs: assert property (reg_rd && reg_addr == GPMUX_IDX_LVL |=>
      ((reg_rdata ^ $past(pin_out)) & $past(pin_oe) & 8'h0f) == 8'h00)
      else $error("level read mismatch");
   a_ctl_readback: assert property (reg_rd && reg_addr == GPMUX_IDX_CTL |=>
      reg_rdata == {6'h00, $past(ctl_q)}) else $error("control readback");
   a_srst_starts: assert property (wr_ok && reg_addr == GPMUX_IDX_CTL
      && reg_wdata[3] |-> ##[1:2] soft_reset) else $error("no soft reset");
   a_srst_ends: assert property ($rose(soft_reset) |-> ##[1:8] !soft_reset)
      else $error("soft reset stuck");
   // modem status runs two stages behind the mode bit
   a_io_quiet: assert property (!ctl_q[1] && !$past(ctl_q[1]) &&
      !$past(ctl_q[1], 2) |-> modem_status == 3'h0 && !modem_irq)
      else $error("modem leak");
   a_modem_dir_kept: assert property (ctl_q[1] && $past(ctl_q[1]) && dir_wr
      |-> ##2 $stable(pin_oe[7:4])) else $error("modem pin direction moved");
endmodule // gpmux_port_checker
bind gpmux_port gpmux_port_checker #(.W(W)) gpmux_port_checker_inst (.*);

// file: sim/gpmux_pins.sv
// gpmux_pins: far-side model of the eight pins
`timescale 1ns/10ps
module gpmux_pins #(
   parameter int W = 8
) (
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] ext_level,
   output logic [W-1:0] pin_in
);
   // a driven pin reads back the port's drive, others follow outside
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gpmux_pins

// file: sim/gpio_port_with_modem_mux_bench.sv
// gpio_port_with_modem_mux_bench: self-checking bench for gpmux_port
`timescale 1ns/10ps
module gpio_port_with_modem_mux_bench;
   import gpmux_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] ext = 8'h00;
   logic dtr_level = 1'b0;
   logic modem_irq_en = 1'b0;
   logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, d;
   logic [2:0] modem_status, s;
   logic modem_irq, pin_irq, soft_reset;
   int errors = 0;
   int n_tests = 0;
   initial forever #12.5 clock = ~clock;
   gpmux_port gpmux_port_inst (
      .clock(clock),
      .reset(reset),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .pin_in(pin_in),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .dtr_level(dtr_level),
      .modem_irq_en(modem_irq_en),
      .modem_status(modem_status),
      .modem_irq(modem_irq),
      .pin_irq(pin_irq),
      .soft_reset(soft_reset)
   );
   gpmux_pins gpmux_pins_inst (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext), .pin_in(pin_in));
   // ---
   // shared tasks
   // ---
   task automatic summarize;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask
   // bounded wait: a miss is counted and ends the run
   task automatic wt(input logic v);
      for (int i = 0; i < 12 && pin_irq !== v; i++) @(negedge clock);
      chk({7'h00, pin_irq}, {7'h00, v});
      if (pin_irq !== v) summarize();
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_out;
      // pin outputs are registered one edge after the register
      acc(1, GPMUX_IDX_DIR, 8'h0f);
      @(negedge clock);
      chk(pin_oe, 8'h0f);
      acc(1, GPMUX_IDX_LVL, 8'h05);
      @(negedge clock);
      chk(pin_out, 8'h05);
      @(posedge clock) ext <= 8'ha0;
      repeat (4) @(negedge clock);
      acc(0, GPMUX_IDX_LVL, 8'h00);
      chk(d, 8'ha5);
   endtask
   task automatic t_unl;
      acc(1, GPMUX_IDX_IEN, 8'h80);
      @(posedge clock) ext[7] <= 1'b0;
      wt(1);
      @(posedge clock) ext[7] <= 1'b1;
      wt(0);
      @(posedge clock) ext[7] <= 1'b0;
      wt(1);
      acc(0, GPMUX_IDX_LVL, 8'h00);
      chk(d, 8'h25);
      @(negedge clock);
      chk({7'h00, pin_irq}, 8'h00);
      @(posedge clock) ext[6] <= 1'b1;
      repeat (8) @(negedge clock);
      chk({7'h00, pin_irq}, 8'h00);
   endtask
   task automatic t_lat;
      acc(1, GPMUX_IDX_CTL, 8'h01);
      acc(1, GPMUX_IDX_IEN, 8'hc0);
      @(posedge clock) ext[6] <= 1'b0;
      wt(1);
      @(posedge clock) ext[6] <= 1'b1;
      repeat (8) @(negedge clock);
      chk({7'h00, pin_irq}, 8'h01);
      acc(0, GPMUX_IDX_LVL, 8'h00);
      chk(d, 8'h25);
      @(negedge clock);
      chk({7'h00, pin_irq}, 8'h00);
      @(posedge clock) ext[7] <= 1'b1;
      wt(1);
      acc(1, GPMUX_IDX_DIR, 8'h0f);
      @(negedge clock);
      chk({7'h00, pin_irq}, 8'h00);
   endtask
   task automatic t_modem;
      acc(1, GPMUX_IDX_CTL, 8'h02);
      @(posedge clock) modem_irq_en <= 1'b1;
      @(posedge clock) dtr_level <= 1'b1;
      acc(1, GPMUX_IDX_IEN, 8'hff);
      acc(1, GPMUX_IDX_DIR, 8'hff);
      s = modem_status;
      @(posedge clock) ext[6] <= 1'b0;
      for (int i = 0; i < 12 && modem_irq !== 1'b1; i++) @(negedge clock);
      chk({7'h00, modem_irq}, 8'h01);
      if (modem_irq !== 1'b1) summarize();
      repeat (2) @(negedge clock);
      chk({5'h00, modem_status ^ s}, 8'h04);
      chk({7'h00, pin_irq}, 8'h00);
      chk({7'h00, pin_out[5]}, 8'h01);
      acc(1, GPMUX_IDX_CTL, 8'h00);
   endtask
   task automatic t_srst;
      acc(1, GPMUX_IDX_CTL, 8'h08);
      repeat (12) @(negedge clock);
      chk({7'h00, soft_reset}, 8'h00);
      chk(pin_oe, 8'h00);
      for (int a = 0; a < 4; a++) begin
         acc(0, a[1:0], 8'h00);
         // all pins are inputs again, so the level shows the outside
         chk(d, (a[1:0] == GPMUX_IDX_LVL) ? ext : 8'h00);
      end
   endtask
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      t_out();
      t_unl();
      t_lat();
      t_modem();
      t_srst();
      summarize();
   end
endmodule // gpio_port_with_modem_mux_bench
